/* File: rtl/dwr_working_regs.sv */
// Purpose: Working registers and two byte queues of one datapath.
// Assumes: clk is the bus clock; datapath edges come as enable pulses.
// Notes:   Bus read data and bus status lag one cycle; block status lags one cycle only with sync direct.
`timescale 1ns/1ps

// ------------------------------------------------------------------------
// Queue storage
// ------------------------------------------------------------------------
module dwr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     wipe,
  input  wire logic                     flush,
  input  wire logic                     single,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  wire              full  = cnt_reg == (AW+1)'(DEPTH);
  wire              empty = cnt_reg == '0;
  wire              pop   = out_ready & ~empty & ~single;
  // A write into a full queue lands on the head slot and moves no pointer, so the next read returns it.
  wire              over  = in_valid & full & ~pop;

  always_ff @(posedge clk)
  begin
    if (rst | wipe | flush)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else if (!single)
    begin
      if (in_valid & ~over)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
      if (in_valid & ~pop & ~full)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop & ~in_valid)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst | wipe)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= '0;
    end
    else if (in_valid)
      mem_reg[single ? '0 : wr_reg] <= in_data;
  end

  assign out_data  = single ? mem_reg[0] : mem_reg[rd_reg];
  assign out_valid = single | ~empty;
  assign in_ready  = single | ~full;
  assign level     = cnt_reg;
endmodule

// ------------------------------------------------------------------------
// Working register block
// ------------------------------------------------------------------------
module dwr_working_regs (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          wake,
  input  wire logic                          dp_rise_en,
  input  wire logic                          dp_fall_en,
  input  wire logic [dwr_pkg::DWR_AW-1:0]    bus_addr,
  input  wire logic                          bus_wr,
  input  wire logic                          bus_rd,
  input  wire logic [dwr_pkg::DWR_DW-1:0]    bus_wdata,
  output logic [dwr_pkg::DWR_DW-1:0]         bus_rdata,
  input  wire logic [1:0]                    acc_wr_en,
  input  wire logic [dwr_pkg::DWR_DW-1:0]    acc_zero_wdata,
  input  wire logic [dwr_pkg::DWR_DW-1:0]    acc_one_wdata,
  input  wire logic [dwr_pkg::DWR_DW-1:0]    alu_result,
  input  wire logic [1:0]                    queue_load_control,
  input  wire logic [1:0]                    data_load,
  input  wire logic [1:0]                    queue_take,
  input  wire logic                          capture_chain_in,
  output logic                               capture_chain_out,
  output logic [dwr_pkg::DWR_DW-1:0]         accumulator_zero,
  output logic [dwr_pkg::DWR_DW-1:0]         accumulator_one,
  output logic [dwr_pkg::DWR_DW-1:0]         data_constant_zero,
  output logic [dwr_pkg::DWR_DW-1:0]         data_constant_one,
  output logic [dwr_pkg::DWR_DW-1:0]         queue_head_zero,
  output logic [dwr_pkg::DWR_DW-1:0]         queue_head_one,
  output logic [1:0]                         queue_bus_status,
  output logic [1:0]                         queue_block_status
);
  import dwr_pkg::*;

  logic [7:0] acc_reg [2];
  logic [7:0] dat_reg [2];
  logic [7:0] head_reg [2];
  logic [7:0] aux_reg;
  logic [7:0] cfga_reg;
  logic [7:0] cfgb_reg;
  logic [7:0] rdata_reg;
  logic       chain_reg;
  logic [1:0] bus_stat_reg;
  logic [1:0] blk_stat_reg;
  logic [7:0] q_out [2];
  logic [2:0] q_cnt [2];
  wire  [7:0] acc_in [2];

  assign acc_in[0] = acc_zero_wdata;
  assign acc_in[1] = acc_one_wdata;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire wr_aux    = bus_wr & (bus_addr == OFS_AUX);
  wire wr_cfga   = bus_wr & (bus_addr == OFS_CFGA);
  wire wr_cfgb   = bus_wr & (bus_addr == OFS_CFGB);
  wire rd_acc0   = bus_rd & (bus_addr == OFS_ACC0);
  wire rd_acc1   = bus_rd & (bus_addr == OFS_ACC1);
  wire edge_mode = cfga_reg[CFGA_EDGE];
  wire fast_mode = cfga_reg[CFGA_FAST];
  wire cap_mode  = cfgb_reg[CFGB_CAP];
  wire chain_on  = cfgb_reg[CFGB_CHAIN];
  wire [1:0] sync_sel = cfgb_reg[CFGB_SYNC +: 2];
  // Only an enabled chain may inject captures into this datapath.
  wire chain_cap = chain_on & capture_chain_in;

  wire [7:0] rd_mux =
    (bus_addr == OFS_ACC0) ? acc_reg[0] :
    (bus_addr == OFS_ACC1) ? acc_reg[1] :
    (bus_addr == OFS_DAT0) ? dat_reg[0] :
    (bus_addr == OFS_DAT1) ? dat_reg[1] :
    (bus_addr == OFS_Q0)   ? q_out[0]   :
    (bus_addr == OFS_Q1)   ? q_out[1]   :
    (bus_addr == OFS_AUX)  ? aux_reg    :
    (bus_addr == OFS_CFGA) ? cfga_reg   :
    (bus_addr == OFS_CFGB) ? cfgb_reg   : DWR_RST_VAL;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aux_reg   <= DWR_RST_VAL;
      cfga_reg  <= DWR_RST_VAL;
      cfgb_reg  <= DWR_RST_VAL;
      rdata_reg <= DWR_RST_VAL;
      chain_reg <= 1'b0;
    end
    else
    begin
      if (wr_aux)
        aux_reg <= bus_wdata & AUX_MASK;
      if (wr_cfga)
        cfga_reg <= bus_wdata;
      if (wr_cfgb)
        cfgb_reg <= bus_wdata & CFGB_MASK;
      if (bus_rd)
        rdata_reg <= rd_mux;
      chain_reg <= cap_mode & chain_on & (rd_acc0 | rd_acc1 | capture_chain_in);
    end
  end

  // ----------------------------------------------------------------------
  // Per-queue logic
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < 2; g++)
  begin : gen_q
    wire [3:0] ofs_acc = g ? OFS_ACC1 : OFS_ACC0;
    wire [3:0] ofs_dat = g ? OFS_DAT1 : OFS_DAT0;
    wire [3:0] ofs_q   = g ? OFS_Q1 : OFS_Q0;
    wire [1:0] sel     = cfga_reg[CFGA_SEL0 + 2*g +: 2];
    wire       is_out  = sel != DWR_SRC_BUS;
    wire       clr     = aux_reg[AUX_CLR0 + g];
    wire       lvl     = aux_reg[AUX_LVL0 + g];
    wire       dp_en   = cfga_reg[CFGA_CKINV0 + g] ? dp_fall_en : dp_rise_en;
    wire       smp_en  = (fast_mode & is_out) | dp_en;
    logic      ld_prev_reg;
    wire       ld_hit  = edge_mode ? (queue_load_control[g] & ~ld_prev_reg) : queue_load_control[g];
    wire       hw_wr   = is_out & smp_en & ld_hit;
    wire       sw_wr   = cap_mode & is_out & ((bus_rd & (bus_addr == ofs_acc)) | chain_cap);
    wire [7:0] src     = (sel == DWR_SRC_ACC0) ? acc_reg[0] :
                         (sel == DWR_SRC_ACC1) ? acc_reg[1] :
                         (sel == DWR_SRC_ALU)  ? alu_result : bus_wdata;
    wire       push    = is_out ? (hw_wr | sw_wr) : (bus_wr & (bus_addr == ofs_q));
    wire [7:0] wdata   = (is_out & sw_wr) ? acc_reg[g] : src;
    wire       dp_pop  = dp_en & (data_load[g] | queue_take[g]);
    wire       pop     = is_out ? (bus_rd & (bus_addr == ofs_q)) : dp_pop;
    wire       flush   = wr_aux & bus_wdata[AUX_CLR0 + g];
    wire [2:0] thr     = lvl ? DWR_LVL_HI : DWR_LVL_LO;
    wire [2:0] fill    = is_out ? q_cnt[g] : (DWR_FULL_CNT - q_cnt[g]);
    wire       bus_raw = ~clr & (fill >= thr);
    wire       blk_raw = ~clr & (is_out ? (q_cnt[g] == DWR_FULL_CNT) : (q_cnt[g] == 3'h0));
    logic      samp_reg;
    logic      sync_a_reg;
    logic      sync_b_reg;
    wire       blk_sel = (sync_sel == DWR_SYNC_DIRECT) ? blk_raw :
                         (sync_sel == DWR_SYNC_SINGLE) ? samp_reg : sync_b_reg;

    dwr_fifo #(
      .WIDTH (DWR_DW),
      .DEPTH (DWR_DEPTH)
    ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .wipe      (wake),
      .flush     (flush),
      .single    (clr),
      .in_valid  (push),
      .in_ready  (),
      .in_data   (wdata),
      .out_valid (),
      .out_ready (pop),
      .out_data  (q_out[g]),
      .level     (q_cnt[g])
    );

    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        ld_prev_reg     <= 1'b0;
        samp_reg        <= 1'b0;
        sync_a_reg      <= 1'b0;
        sync_b_reg      <= 1'b0;
        bus_stat_reg[g] <= 1'b0;
        blk_stat_reg[g] <= 1'b0;
        head_reg[g]     <= DWR_RST_VAL;
      end
      else
      begin
        if (smp_en)
          ld_prev_reg <= queue_load_control[g];
        if (dp_en)
        begin
          samp_reg   <= blk_raw;
          sync_a_reg <= blk_raw;
          sync_b_reg <= sync_a_reg;
        end
        bus_stat_reg[g] <= bus_raw;
        blk_stat_reg[g] <= blk_sel;
        head_reg[g]     <= q_out[g];
      end
    end

    always_ff @(posedge clk)
    begin
      if (rst | wake)
        acc_reg[g] <= DWR_RST_VAL;
      else if (bus_wr & (bus_addr == ofs_acc))
        acc_reg[g] <= bus_wdata;
      else if (acc_wr_en[g])
        acc_reg[g] <= acc_in[g];
    end

    always_ff @(posedge clk)
    begin
      if (rst)
        dat_reg[g] <= DWR_RST_VAL;
      else if (bus_wr & (bus_addr == ofs_dat))
        dat_reg[g] <= bus_wdata;
      else if (~is_out & dp_en & data_load[g])
        dat_reg[g] <= q_out[g];
    end

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    wire quiet = ~bus_wr & ~bus_rd & ~wake & ~clr;

    acc_wake_a: assert property (@(posedge clk) disable iff (rst)
      wake |=> acc_reg[g] == 8'h00 && q_cnt[g] == 3'h0)
      else $error("accumulator or queue not cleared by wake");
    dat_keep_a: assert property (@(posedge clk) disable iff (rst)
      wake && !(bus_wr && bus_addr == ofs_dat) && !(data_load[g] && !is_out) |=> $stable(dat_reg[g]))
      else $error("data constant changed across wake");
    bus_level_a: assert property (@(posedge clk) disable iff (rst)
      !is_out && !clr && lvl && q_cnt[g] == 3'h3 |=> !queue_bus_status[g])
      else $error("input bus status with one free byte at high level");
    out_level_a: assert property (@(posedge clk) disable iff (rst)
      is_out && !clr && !lvl && q_cnt[g] == 3'h1 |=> queue_bus_status[g])
      else $error("output bus status missing with one byte");
    blk_full_a: assert property (@(posedge clk) disable iff (rst)
      is_out && !clr && sync_sel == DWR_SYNC_DIRECT && q_cnt[g] == DWR_FULL_CNT |=> queue_block_status[g])
      else $error("output block status missing when full");
    blk_empty_a: assert property (@(posedge clk) disable iff (rst)
      !is_out && !clr && sync_sel == DWR_SYNC_DIRECT && q_cnt[g] != 3'h0 |=> !queue_block_status[g])
      else $error("input block status while not empty");
    level_write_a: assert property (@(posedge clk) disable iff (rst)
      quiet && is_out && !edge_mode && fast_mode && queue_load_control[g] && q_cnt[g] < DWR_FULL_CNT
      |=> q_cnt[g] == $past(q_cnt[g]) + 3'h1)
      else $error("level load did not write queue");
    edge_once_a: assert property (@(posedge clk) disable iff (rst)
      (quiet && !chain_cap && is_out && edge_mode && fast_mode && queue_load_control[g]) [*2]
      |=> q_cnt[g] == $past(q_cnt[g]))
      else $error("held edge load wrote twice");
    sw_capture_a: assert property (@(posedge clk) disable iff (rst)
      cap_mode && is_out && !clr && !wake && bus_rd && bus_addr == ofs_acc && q_cnt[g] < DWR_FULL_CNT
      |=> q_cnt[g] == $past(q_cnt[g]) + 3'h1)
      else $error("accumulator read did not capture");
    clr_reset_a: assert property (@(posedge clk) disable iff (rst)
      flush |=> q_cnt[g] == 3'h0 ##1 (clr -> q_cnt[g] == 3'h0))
      else $error("clear did not reset queue");

    fill_cov: cover property (@(posedge clk) disable iff (rst) q_cnt[g] == DWR_FULL_CNT ##1 q_cnt[g] == 3'h3);
    cap_cov: cover property (@(posedge clk) disable iff (rst) sw_wr && hw_wr);
    single_cov: cover property (@(posedge clk) disable iff (rst) clr && push ##1 pop);
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign bus_rdata          = rdata_reg;
  assign capture_chain_out  = chain_reg;
  assign accumulator_zero   = acc_reg[0];
  assign accumulator_one    = acc_reg[1];
  assign data_constant_zero = dat_reg[0];
  assign data_constant_one  = dat_reg[1];
  assign queue_head_zero    = head_reg[0];
  assign queue_head_one     = head_reg[1];
  assign queue_bus_status   = bus_stat_reg;
  assign queue_block_status = blk_stat_reg;
endmodule

/* File: common/dwr_pkg.sv */
// Purpose: Constants for the datapath working registers and queue block.
// Assumes: One bus clock; datapath clock edges arrive as enable pulses.
// Notes:   Offsets index the byte-wide system bus register window.

package dwr_pkg;

  localparam int          DWR_DW        = 8;
  localparam int          DWR_DEPTH     = 4;
  localparam int          DWR_AW        = 4;
  localparam logic [2:0]  DWR_FULL_CNT  = 3'h4;
  localparam logic [2:0]  DWR_LVL_LO    = 3'h1;
  localparam logic [2:0]  DWR_LVL_HI    = 3'h2;
  localparam logic [7:0]  DWR_RST_VAL   = 8'h00;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0]  OFS_ACC0      = 4'h0;
  localparam logic [3:0]  OFS_ACC1      = 4'h1;
  localparam logic [3:0]  OFS_DAT0      = 4'h2;
  localparam logic [3:0]  OFS_DAT1      = 4'h3;
  localparam logic [3:0]  OFS_Q0        = 4'h4;
  localparam logic [3:0]  OFS_Q1        = 4'h5;
  localparam logic [3:0]  OFS_AUX       = 4'h6;
  localparam logic [3:0]  OFS_CFGA      = 4'h7;
  localparam logic [3:0]  OFS_CFGB      = 4'h8;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int          AUX_CLR0      = 0;
  localparam int          AUX_LVL0      = 2;
  localparam logic [7:0]  AUX_MASK      = 8'h0f;
  localparam int          CFGA_SEL0     = 0;
  localparam int          CFGA_CKINV0   = 4;
  localparam int          CFGA_FAST     = 6;
  localparam int          CFGA_EDGE     = 7;
  localparam int          CFGB_CAP      = 0;
  localparam int          CFGB_CHAIN    = 1;
  localparam int          CFGB_SYNC     = 2;
  localparam logic [7:0]  CFGB_MASK     = 8'h0f;

  typedef enum logic [1:0] {
    DWR_SRC_BUS  = 2'b00,
    DWR_SRC_ACC0 = 2'b01,
    DWR_SRC_ACC1 = 2'b10,
    DWR_SRC_ALU  = 2'b11
  } dwr_src_t;

  typedef enum logic [1:0] {
    DWR_SYNC_DIRECT = 2'b00,
    DWR_SYNC_SINGLE = 2'b01,
    DWR_SYNC_DOUBLE = 2'b10
  } dwr_sync_t;

endpackage

/* File: dv/dwr_bus_model.sv */
// Purpose: System bus master that reaches the working registers.
// Assumes: Byte access, one request per call, bus_rdata valid one cycle after the read.
// Notes:   Idle lines carry the inverse of the last value so stale data never looks valid.
`timescale 1ns/1ps

module dwr_bus_model (
  input  wire logic       clk,
  output logic [3:0]      bus_addr,
  output logic            bus_wr,
  output logic            bus_rd,
  output logic [7:0]      bus_wdata,
  input  wire logic [7:0] bus_rdata
);
  initial
  begin
    bus_addr  = 4'h0;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bus_wdata = 8'h00;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int gap;
    gap = $urandom % 3;
    repeat (gap) @(posedge clk);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr    <= 1'b0;
    bus_addr  <= ~a;
    bus_wdata <= ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    int gap;
    gap = $urandom % 3;
    repeat (gap) @(posedge clk);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd   <= 1'b0;
    bus_addr <= ~a;
    @(posedge clk);
    d = bus_rdata;
  endtask
endmodule

/* File: dv/dwr_working_regs_test.sv */
// Purpose: Self-checking bench for the working registers and queues.
// Assumes: Status sync direct except one double-sampled case; a queue model predicts the data_const, drain and stat results.
// Notes:   Edge mode is only exercised with the fast option.
`timescale 1ns/1ps

module dwr_working_regs_test;
  import dwr_pkg::*;
  logic       clk, rst, wake, dp_rise_en, dp_fall_en, bus_wr, bus_rd;
  logic       capture_chain_in, capture_chain_out;
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, acc_zero_wdata, acc_one_wdata, alu_result, d, v;
  logic [7:0] accumulator_zero, accumulator_one, data_constant_zero, data_constant_one;
  logic [7:0] queue_head_zero, queue_head_one;
  logic [1:0] acc_wr_en, queue_load_control, data_load, queue_take, queue_bus_status, queue_block_status;
  logic [7:0] av[2];
  int         mq[2][$];
  int         errors, compares;

  dwr_working_regs i_dut (.clk(clk), .rst(rst), .wake(wake), .dp_rise_en(dp_rise_en),
    .dp_fall_en(dp_fall_en), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .acc_wr_en(acc_wr_en),
    .acc_zero_wdata(acc_zero_wdata), .acc_one_wdata(acc_one_wdata), .alu_result(alu_result),
    .queue_load_control(queue_load_control), .data_load(data_load), .queue_take(queue_take),
    .capture_chain_in(capture_chain_in), .capture_chain_out(capture_chain_out),
    .accumulator_zero(accumulator_zero), .accumulator_one(accumulator_one),
    .data_constant_zero(data_constant_zero), .data_constant_one(data_constant_one),
    .queue_head_zero(queue_head_zero), .queue_head_one(queue_head_one),
    .queue_bus_status(queue_bus_status), .queue_block_status(queue_block_status));

  dwr_bus_model i_bus (.clk(clk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // A full queue takes the new byte at its head, the count stays put.
  task automatic put(input int q, input logic [7:0] x);
    if (mq[q].size() == 4)
      mq[q][0] = x;
    else
      mq[q].push_back(x);
  endtask

  task automatic stat(input int q, input bit inm, input bit lvl);
    int         n;
    logic [7:0] eb, ek;
    n  = mq[q].size();
    eb = inm ? 8'(4 - n >= 1 + lvl) : 8'(n >= 1 + lvl);
    ek = inm ? 8'(n == 0) : 8'(n == 4);
    repeat (3) @(posedge clk);
    chk("bus_status", {7'h00, queue_bus_status[q]}, eb);
    chk("block_status", {7'h00, queue_block_status[q]}, ek);
  endtask

  task automatic dp(input logic fall, input logic [1:0] ld, input logic [1:0] tk, input logic [1:0] lc);
    @(posedge clk);
    dp_rise_en         <= ~fall;
    dp_fall_en         <= fall;
    data_load          <= ld;
    queue_take         <= tk;
    queue_load_control <= lc;
    @(posedge clk);
    dp_rise_en         <= 1'b0;
    dp_fall_en         <= 1'b0;
    data_load          <= 2'b00;
    queue_take         <= 2'b00;
    queue_load_control <= 2'b00;
    repeat (3) @(posedge clk);
  endtask

  task automatic setacc;
    av[0] = 8'($urandom);
    av[1] = 8'($urandom);
    @(posedge clk);
    acc_wr_en      <= 2'b11;
    acc_zero_wdata <= av[0];
    acc_one_wdata  <= av[1];
    alu_result     <= 8'($urandom);
    dp_rise_en     <= 1'b1;
    @(posedge clk);
    acc_wr_en      <= 2'b00;
    dp_rise_en     <= 1'b0;
    acc_zero_wdata <= ~av[0];
    acc_one_wdata  <= ~av[1];
    repeat (2) @(posedge clk);
    chk("acc_zero", accumulator_zero, av[0]);
    chk("acc_one", accumulator_one, av[1]);
  endtask

  task automatic drain(input bit lvl);
    for (int q = 0; q < 2; q++)
      while (mq[q].size() > 0)
      begin
        chk("queue_head", q ? queue_head_one : queue_head_zero, 8'(mq[q][0]));
        i_bus.rd(4'(OFS_Q0 + q), d);
        chk("queue_out", d, 8'(mq[q].pop_front()));
        stat(q, 1'b0, lvl);
      end
  endtask

  task automatic hold_load;
    @(posedge clk);
    queue_load_control <= 2'b11;
    repeat (3) @(posedge clk);
    queue_load_control <= 2'b00;
    repeat (3) @(posedge clk);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #200us;
    errors++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    errors = 0; compares = 0; rst = 1'b1; wake = 1'b0; dp_rise_en = 1'b0; dp_fall_en = 1'b0;
    acc_wr_en = 2'b00; acc_zero_wdata = 8'h00; acc_one_wdata = 8'h00; alu_result = 8'h00;
    queue_load_control = 2'b00; data_load = 2'b00; queue_take = 2'b00; capture_chain_in = 1'b0;
    v = 8'($urandom(63));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 9; a++)
      if (a != 4 && a != 5)
      begin
        i_bus.rd(4'(a), d);
        chk("reset_value", d, 8'h00);
      end
    i_bus.rd(4'hf, d);
    chk("unmapped", d, 8'h00);
    for (int a = 0; a < 4; a++)
    begin
      v = 8'($urandom);
      i_bus.wr(4'(a), v);
      i_bus.rd(4'(a), d);
      chk("work_reg", d, v);
    end
    for (int q = 0; q < 2; q++)
      for (int l = 0; l < 2; l++)
      begin
        i_bus.wr(OFS_AUX, l ? 8'h0c : 8'h00);
        for (int k = 0; k < 5; k++)
        begin
          v = 8'($urandom);
          i_bus.wr(4'(OFS_Q0 + q), v);
          put(q, v);
          stat(q, 1'b1, l[0]);
        end
        for (int k = 0; k < 4; k++)
        begin
          dp(1'b0, 2'(1 << q), 2'b00, 2'b00);
          chk("data_const", q ? data_constant_one : data_constant_zero, 8'(mq[q].pop_front()));
          stat(q, 1'b1, l[0]);
        end
      end
    i_bus.wr(OFS_AUX, 8'h00);
    i_bus.wr(OFS_CFGA, 8'h10);
    for (int k = 0; k < 2; k++)
    begin
      i_bus.wr(OFS_Q0, 8'($urandom));
      put(0, 8'h00);
    end
    dp(1'b0, 2'b00, 2'b01, 2'b00);
    stat(0, 1'b1, 1'b0);
    dp(1'b1, 2'b00, 2'b01, 2'b00);
    void'(mq[0].pop_front());
    stat(0, 1'b1, 1'b0);
    i_bus.wr(OFS_AUX, 8'h03);
    i_bus.wr(OFS_AUX, 8'h00);
    mq[0].delete();
    for (int s = 1; s < 4; s++)
    begin
      i_bus.wr(OFS_CFGA, {4'h0, 2'(s), 2'(s)});
      setacc();
      dp(1'b0, 2'b00, 2'b00, 2'b11);
      for (int q = 0; q < 2; q++)
        put(q, s == 1 ? av[0] : s == 2 ? av[1] : alu_result);
      drain(1'b0);
    end
    // fill past full from the ALU
    i_bus.wr(OFS_AUX, 8'h0c);
    for (int k = 0; k < 5; k++)
    begin
      @(posedge clk);
      alu_result <= 8'($urandom);
      dp(1'b0, 2'b00, 2'b00, 2'b11);
      put(0, alu_result);
      put(1, alu_result);
      stat(0, 1'b0, 1'b1);
      stat(1, 1'b0, 1'b1);
    end
    drain(1'b1);
    i_bus.wr(OFS_AUX, 8'h00);
    i_bus.wr(OFS_CFGA, 8'hc9);
    setacc();
    hold_load();
    put(0, av[0]);
    put(1, av[1]);
    drain(1'b0);
    i_bus.wr(OFS_CFGA, 8'h49);
    hold_load();
    for (int k = 0; k < 3; k++)
    begin
      put(0, av[0]);
      put(1, av[1]);
    end
    drain(1'b0);
    i_bus.wr(OFS_CFGA, 8'h09);
    i_bus.wr(OFS_CFGB, 8'h03);
    setacc();
    i_bus.rd(OFS_ACC0, d);
    put(0, av[0]);
    i_bus.rd(OFS_ACC1, d);
    put(1, av[1]);
    drain(1'b0);
    @(posedge clk);
    capture_chain_in <= 1'b1;
    @(posedge clk);
    capture_chain_in <= 1'b0;
    #1;
    chk("chain_out", {7'h00, capture_chain_out}, 8'h01);
    put(0, av[0]);
    put(1, av[1]);
    repeat (2) @(posedge clk);
    drain(1'b0);
    i_bus.wr(OFS_CFGB, 8'h00);
    // held clear gives a single buffer
    i_bus.wr(OFS_CFGA, 8'h01);
    i_bus.wr(OFS_AUX, 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      setacc();
      dp(1'b0, 2'b00, 2'b00, 2'b01);
    end
    chk("clr_bus_status", {7'h00, queue_bus_status[0]}, 8'h00);
    chk("clr_block_status", {7'h00, queue_block_status[0]}, 8'h00);
    i_bus.rd(OFS_Q0, d);
    chk("single_buffer", d, av[0]);
    i_bus.wr(OFS_AUX, 8'h03);
    i_bus.wr(OFS_AUX, 8'h00);
    // double-sampled block status waits for two datapath edges
    i_bus.wr(OFS_CFGB, 8'h08);
    v = 8'($urandom);
    i_bus.wr(OFS_Q1, v);
    put(1, v);
    repeat (3) @(posedge clk);
    for (int k = 0; k < 3; k++)
    begin
      chk("sync_block", {7'h00, queue_block_status[1]}, 8'(k < 2));
      dp(1'b0, 2'b00, 2'b00, 2'b00);
    end
    i_bus.wr(OFS_CFGB, 8'h00);
    // wakeup clears accumulators and queues but not data constants
    setacc();
    dp(1'b0, 2'b00, 2'b00, 2'b01);
    v = 8'($urandom);
    i_bus.wr(OFS_DAT0, v);
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wake_acc0", accumulator_zero, 8'h00);
    chk("wake_acc1", accumulator_one, 8'h00);
    chk("wake_data0", data_constant_zero, v);
    chk("wake_head0", queue_head_zero, 8'h00);
    chk("wake_head1", queue_head_one, 8'h00);
    mq[0].delete();
    mq[1].delete();
    stat(0, 1'b0, 1'b0);
    wrap_up();
  end
endmodule
